/* phymip_chk.sv */
// Assertion checker for the media-independent port
`timescale 1ns/10ps
module phymip_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Rate and medium status
    input wire logic speed_100,
    input wire logic collision_src,
    input wire logic carrier_src,
    // Receive side pins
    input wire logic rx_clk,
    input wire logic [phymip_pkg::PHYMIP_NIB_W-1:0] rxd,
    input wire logic rx_dv_in,
    input wire logic rx_dv_out,
    input wire logic rx_dv_oe,
    input wire logic rx_er_in,
    input wire logic rx_er_out,
    input wire logic rx_er_oe,
    input wire logic col_in,
    input wire logic col_out,
    input wire logic col_oe,
    input wire logic crs_in,
    input wire logic crs_out,
    input wire logic crs_oe,
    // Transmit side
    input wire logic tx_clk_oe,
    input wire logic tx_nib_valid,
    // Latched settings
    input wire logic coding_layer_loopback_strap,
    input wire logic port_detach_mode,
    input wire logic reduced_if_select_strap,
    input wire logic reduced_if_back_to_back_strap,
    input wire logic port_running
);
    import phymip_pkg::*;
    localparam int HALF_FAST = 2;
    localparam int HALF_SLOW = 20;
    logic prev_r;
    logic tog;
    logic [5:0] half_r;
    logic [1:0] tog_r;
    assign tog = rx_clk != prev_r;
    // Measure each half period of the receive clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_r <= 1'b0;
            half_r <= 6'h00;
            tog_r <= 2'h0;
        end else begin
            prev_r <= rx_clk;
            half_r <= tog ? 6'h00 : half_r + 6'h01;
            if (tog && tog_r != 2'h3) begin
                tog_r <= tog_r + 2'h1;
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    rxc_rate_a:
    assert property (tog && tog_r >= 2'h2 |-> half_r == (speed_100 ? HALF_FAST - 1 : HALF_SLOW - 1))
        else $error("receive clock half period wrong");
    strap_latch_a:
    assert property ($rose(port_running) |-> coding_layer_loopback_strap == rx_dv_in
        && port_detach_mode == rx_er_in && reduced_if_select_strap == col_in
        && reduced_if_back_to_back_strap == (crs_in && col_in))
        else $error("strap latched wrong");
    strap_hold_a:
    assert property (port_running && $past(port_running) |-> $stable({coding_layer_loopback_strap,
        port_detach_mode, reduced_if_select_strap, reduced_if_back_to_back_strap}))
        else $error("strap changed after latch");
    oe_idle_a:
    assert property (!port_running |-> !(rx_dv_oe || rx_er_oe || col_oe || crs_oe || tx_clk_oe))
        else $error("pin driven before running");
    oe_drive_a:
    assert property ($rose(port_running) && !port_detach_mode |-> ##1
        (rx_dv_oe && rx_er_oe && col_oe && crs_oe)) else $error("pins not driven");
    detach_quiet_a:
    assert property (port_detach_mode |-> !(rx_dv_oe || rx_er_oe || col_oe || crs_oe || tx_clk_oe))
        else $error("detached port drives a pin");
    txc_dir_a:
    assert property (port_running && $past(port_running) |->
        tx_clk_oe == (!port_detach_mode && !reduced_if_select_strap))
        else $error("transmit clock direction wrong");
    col_follow_a:
    assert property (port_running && $past(port_running) |-> col_out == $past(collision_src))
        else $error("collision pin wrong");
    crs_follow_a:
    assert property (port_running && $past(port_running) && $past(carrier_src) |-> crs_out)
        else $error("carrier pin low");
    dv_edge_a:
    assert property (rx_dv_out != $past(rx_dv_out) |-> $fell(rx_clk))
        else $error("valid moved off receive clock fall");
    rx_idle_a:
    assert property (!rx_dv_out |-> rxd == 4'h0 && !rx_er_out)
        else $error("data or error without valid");
    tx_pulse_a:
    assert property (tx_nib_valid |-> port_running ##1 !tx_nib_valid)
        else $error("transmit pulse wrong");
endmodule
bind phymip_port phymip_chk i_phymip_chk (
    .clk, .reset_n, .speed_100, .collision_src, .carrier_src, .rx_clk, .rxd,
    .rx_dv_in, .rx_dv_out, .rx_dv_oe, .rx_er_in, .rx_er_out, .rx_er_oe,
    .col_in, .col_out, .col_oe, .crs_in, .crs_out, .crs_oe, .tx_clk_oe, .tx_nib_valid,
    .coding_layer_loopback_strap, .port_detach_mode, .reduced_if_select_strap,
    .reduced_if_back_to_back_strap, .port_running
);

/* phymip_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module phymip_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    // Handshake terms; full and empty come from the occupancy count
    assign in_ready = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data = mem[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage array
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule

/* phymip_mac_model.sv */
// Behavioural MAC facing the port's media-independent pins
`timescale 1ns/10ps
module phymip_mac_model (
    // Clocks
    input wire logic link_clk,
    input wire logic rx_clk,
    // Receive pins
    input wire logic rx_dv,
    input wire logic rx_er,
    input wire logic [3:0] rxd,
    // Transmit pins
    output logic tx_en,
    output logic tx_er,
    output logic [3:0] txd
);
    logic [4:0] tx_q[$];
    logic [4:0] rx_q[$];
    logic [4:0] w;
    initial begin
        tx_en = 1'b0;
        tx_er = 1'b0;
        txd = 4'h0;
    end
    // One queued nibble per link clock, launched off the falling edge, opposite the sampling edge
    always @(negedge link_clk) begin
        if (tx_q.size() > 0) begin
            w = tx_q.pop_front();
            tx_en <= 1'b1;
            tx_er <= w[4];
            txd <= w[3:0];
        end else begin
            tx_en <= 1'b0;
            tx_er <= 1'b0;
            txd <= 4'h0;
        end
    end
    // Collect every nibble marked valid
    always @(posedge rx_clk) begin
        if (rx_dv === 1'b1) begin
            rx_q.push_back({rx_er, rxd});
        end
    end
endmodule

/* phymip_pkg.sv */
// Constants and types shared by the media-independent port block
package phymip_pkg;

    // ------------------------------------------------------------
    // Clock rates and receive clock division
    // ------------------------------------------------------------
    localparam int PHYMIP_CLK_HZ = 100_000_000;
    localparam int PHYMIP_RXC_FAST_HZ = 25_000_000;
    localparam int PHYMIP_RXC_SLOW_HZ = 2_500_000;
    localparam int PHYMIP_DIV_W = 5;
    // Half periods of the receive clock, in core clock cycles
    localparam logic [PHYMIP_DIV_W-1:0] PHYMIP_RXC_HALF_FAST =
        PHYMIP_DIV_W'(PHYMIP_CLK_HZ / (2 * PHYMIP_RXC_FAST_HZ));
    localparam logic [PHYMIP_DIV_W-1:0] PHYMIP_RXC_HALF_SLOW =
        PHYMIP_DIV_W'(PHYMIP_CLK_HZ / (2 * PHYMIP_RXC_SLOW_HZ));

    // ------------------------------------------------------------
    // Strap sampling
    // ------------------------------------------------------------
    localparam int PHYMIP_SETTLE_W = 3;
    // Settle counter load; strap pins stay inputs until three cycles after it reaches zero
    localparam logic [PHYMIP_SETTLE_W-1:0] PHYMIP_STRAP_SETTLE = 3'h4;
    // Pulled-down default: mode disabled
    localparam logic PHYMIP_STRAP_DEFAULT = 1'h0;

    // ------------------------------------------------------------
    // Data path widths and buffering
    // ------------------------------------------------------------
    localparam int PHYMIP_NIB_W = 4;
    localparam int PHYMIP_WORD_W = 5;
    localparam int PHYMIP_FIFO_DEPTH = 16;
    localparam int PHYMIP_ERR_BIT = 4;

    // ------------------------------------------------------------
    // Port sequencing states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PHYMIP_ST_SAMPLE = 3'h1,
        PHYMIP_ST_LATCH = 3'h2,
        PHYMIP_ST_RUN = 3'h4
    } phymip_state_e;

endpackage

/* phymip_port.sv */
// Media-independent port of a 10/100 transceiver with reset-time straps
//
// What this block does
// - Receive clock runs 25MHz at 100Mbps, 2.5MHz at 10Mbps.
// - Valid pin level at reset is latched as coding-layer loopback.
// - Error pin level at reset is latched as port detach mode.
// - Collision pin level at reset selects full or reduced interface.
// - Carrier pin level at reset sets reduced back-to-back mode when the collision pin strap is also high.
// - After reset the valid pin is driven, marking valid nibbles.
// - After reset the error pin is driven, flagging receive errors.
// - After reset the collision pin is driven, showing collisions.
// - After reset the carrier pin is driven, showing carrier activity.
// - Full interface drives the transmit clock out to the MAC unless the port is detached.
// - Strap pins are inputs during reset, driven outputs afterwards unless the port is detached.
// - Low strap disables a mode, high strap enables it.
// - Receive data is valid only while the valid pin is high.
// - Straps are captured at power-up and every chip reset.
`timescale 1ns/10ps
module phymip_port (
    // Core clock and chip reset
    input wire logic clk,
    input wire logic reset_n,
    // Link clock from the transmit clock pin, reduced interface
    input wire logic link_clk,
    // Line rate select, high for 100Mbps
    input wire logic speed_100,
    // Received nibble stream from the line side
    input wire logic rx_in_valid,
    output logic rx_in_ready,
    input wire logic [phymip_pkg::PHYMIP_NIB_W-1:0] rx_in_data,
    input wire logic rx_in_err,
    // Medium status from the line side
    input wire logic carrier_src,
    input wire logic collision_src,
    // Receive clock and data pins
    output logic rx_clk,
    output logic [phymip_pkg::PHYMIP_NIB_W-1:0] rxd,
    // Receive data valid pin, strap for coding-layer loopback
    input wire logic rx_dv_in,
    output logic rx_dv_out,
    output logic rx_dv_oe,
    // Receive error pin, strap for port detach
    input wire logic rx_er_in,
    output logic rx_er_out,
    output logic rx_er_oe,
    // Collision pin, strap for reduced interface select
    input wire logic col_in,
    output logic col_out,
    output logic col_oe,
    // Carrier sense pin, strap for reduced back-to-back mode
    input wire logic crs_in,
    output logic crs_out,
    output logic crs_oe,
    // Transmit clock pin driven in the full interface
    output logic tx_clk_out,
    output logic tx_clk_oe,
    // Transmit pins from the MAC, timed to link_clk
    input wire logic tx_en,
    input wire logic tx_er,
    input wire logic [phymip_pkg::PHYMIP_NIB_W-1:0] txd,
    // Transmit nibbles toward the line side
    output logic tx_nib_valid,
    output logic [phymip_pkg::PHYMIP_NIB_W-1:0] tx_nib,
    output logic tx_nib_err,
    // Latched strap settings
    output logic coding_layer_loopback_strap,
    output logic port_detach_mode,
    output logic reduced_if_select_strap,
    output logic reduced_if_back_to_back_strap,
    output logic port_running
);
    import phymip_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    phymip_state_e state_r;
    phymip_state_e state_nxt;
    logic [PHYMIP_SETTLE_W-1:0] settle_r;
    logic [3:0] strap_s1_r;
    logic [3:0] strap_s2_r;
    logic loop_r;
    logic detach_r;
    logic rmii_r;
    logic btb_r;
    logic [PHYMIP_DIV_W-1:0] div_r;
    logic rx_clk_r;
    logic rxc_fall;
    logic [PHYMIP_NIB_W-1:0] rxd_r;
    logic dv_out_r;
    logic er_out_r;
    logic col_out_r;
    logic crs_out_r;
    logic pins_oe_r;
    logic txc_oe_r;
    logic [PHYMIP_WORD_W-1:0] lk_word_r;
    logic lk_tgl_r;
    logic tgl_s1_r;
    logic tgl_s2_r;
    logic tgl_s3_r;
    logic tx_evt;
    logic tx_valid_r;
    logic [PHYMIP_NIB_W-1:0] tx_nib_r;
    logic tx_err_r;
    logic [PHYMIP_WORD_W-1:0] lb_word_r;
    logic lb_valid_r;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [PHYMIP_WORD_W-1:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [PHYMIP_WORD_W-1:0] fifo_out_data;
    logic running;

    // Half period reload for the selected line rate
    function automatic logic [PHYMIP_DIV_W-1:0] half_period(input logic fast);
        half_period = fast ? PHYMIP_RXC_HALF_FAST : PHYMIP_RXC_HALF_SLOW;
    endfunction

    assign running = (state_r == PHYMIP_ST_RUN);

    // ------------------------------------------------------------
    // Strap sampling sequence
    // ------------------------------------------------------------

    // Two-stage synchroniser on the strap pins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_s1_r <= '0;
            strap_s2_r <= '0;
        end else begin
            strap_s1_r <= {crs_in, col_in, rx_er_in, rx_dv_in};
            strap_s2_r <= strap_s1_r;
        end
    end

    // Next state: sample pins, latch once, then run until reset
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            PHYMIP_ST_SAMPLE: begin
                if (settle_r == '0) begin
                    state_nxt = PHYMIP_ST_LATCH;
                end
            end
            PHYMIP_ST_LATCH: begin
                state_nxt = PHYMIP_ST_RUN;
            end
            PHYMIP_ST_RUN: begin
                state_nxt = PHYMIP_ST_RUN;
            end
            default: begin
                state_nxt = PHYMIP_ST_SAMPLE;
            end
        endcase
    end

    // State register; every reset restarts the sampling window
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= PHYMIP_ST_SAMPLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Settle counter lets the synchronised pin levels become stable
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            settle_r <= PHYMIP_STRAP_SETTLE;
        end else if (state_r == PHYMIP_ST_SAMPLE && settle_r != '0) begin
            settle_r <= settle_r - 1'b1;
        end
    end

    // Strap capture, once per reset, high level enables the mode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            loop_r <= PHYMIP_STRAP_DEFAULT;
            detach_r <= PHYMIP_STRAP_DEFAULT;
            rmii_r <= PHYMIP_STRAP_DEFAULT;
            btb_r <= PHYMIP_STRAP_DEFAULT;
        end else if (state_r == PHYMIP_ST_LATCH) begin
            loop_r <= strap_s2_r[0];
            detach_r <= strap_s2_r[1];
            rmii_r <= strap_s2_r[2];
            btb_r <= strap_s2_r[2] & strap_s2_r[3];
        end
    end

    // ------------------------------------------------------------
    // Receive and transmit clock generation
    // ------------------------------------------------------------

    // Divider toggles the receive clock every half period
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_r <= PHYMIP_RXC_HALF_FAST - 1'b1;
            rx_clk_r <= 1'b0;
        end else if (div_r == '0) begin
            div_r <= half_period(speed_100) - 1'b1;
            rx_clk_r <= ~rx_clk_r;
        end else begin
            div_r <= div_r - 1'b1;
        end
    end

    // Outputs change on the falling edge so the MAC samples on the rising one
    assign rxc_fall = (div_r == '0) && rx_clk_r;

    // Transmit clock is driven only in the full interface and not detached
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txc_oe_r <= 1'b0;
        end else begin
            txc_oe_r <= running && !rmii_r && !detach_r;
        end
    end

    // ------------------------------------------------------------
    // Transmit capture on the link clock
    // ------------------------------------------------------------

    // Each framed nibble is held and announced by a toggle
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            lk_word_r <= '0;
            lk_tgl_r <= 1'b0;
        end else if (tx_en) begin
            lk_word_r <= {tx_er, txd};
            lk_tgl_r <= ~lk_tgl_r;
        end
    end

    // Toggle synchroniser into the core domain; third stage finds the edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tgl_s1_r <= 1'b0;
            tgl_s2_r <= 1'b0;
            tgl_s3_r <= 1'b0;
        end else begin
            tgl_s1_r <= lk_tgl_r;
            tgl_s2_r <= tgl_s1_r;
            tgl_s3_r <= tgl_s2_r;
        end
    end

    assign tx_evt = tgl_s2_r ^ tgl_s3_r;

    // Held word is stable when the edge is seen; hand it on as a pulse
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_valid_r <= 1'b0;
            tx_nib_r <= '0;
            tx_err_r <= 1'b0;
        end else begin
            tx_valid_r <= tx_evt && running;
            if (tx_evt) begin
                tx_nib_r <= lk_word_r[PHYMIP_NIB_W-1:0];
                tx_err_r <= lk_word_r[PHYMIP_ERR_BIT];
            end
        end
    end

    // Loopback copy of transmitted nibbles into the receive buffer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lb_valid_r <= 1'b0;
            lb_word_r <= '0;
        end else begin
            if (tx_evt && running && loop_r) begin
                lb_valid_r <= 1'b1;
                lb_word_r <= lk_word_r;
            end else if (fifo_in_ready) begin
                lb_valid_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Receive buffer
    // ------------------------------------------------------------

    // Source is the line side, or transmitted nibbles in loopback
    assign fifo_in_valid = loop_r ? lb_valid_r : (rx_in_valid && running);
    assign fifo_in_data = loop_r ? lb_word_r : {rx_in_err, rx_in_data};
    assign rx_in_ready = fifo_in_ready && running && !loop_r;
    // Drained one nibble per receive clock period
    assign fifo_out_ready = rxc_fall && running;

    phymip_fifo #(
        .WIDTH(PHYMIP_WORD_W),
        .DEPTH(PHYMIP_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // ------------------------------------------------------------
    // Receive pins toward the MAC
    // ------------------------------------------------------------

    // Nibble, valid and error update on the receive clock falling edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rxd_r <= '0;
            dv_out_r <= 1'b0;
            er_out_r <= 1'b0;
        end else if (!running) begin
            dv_out_r <= 1'b0;
            er_out_r <= 1'b0;
        end else if (rxc_fall) begin
            dv_out_r <= fifo_out_valid;
            er_out_r <= fifo_out_valid && fifo_out_data[PHYMIP_ERR_BIT];
            rxd_r <= fifo_out_valid ? fifo_out_data[PHYMIP_NIB_W-1:0] : '0;
        end
    end

    // Carrier and collision follow the medium, registered to the pins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            col_out_r <= 1'b0;
            crs_out_r <= 1'b0;
        end else begin
            col_out_r <= running && collision_src;
            crs_out_r <= running && (carrier_src || fifo_out_valid);
        end
    end

    // Pins stay released while straps are sampled or the port is detached
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pins_oe_r <= 1'b0;
        end else begin
            pins_oe_r <= running && !detach_r;
        end
    end

    // ------------------------------------------------------------
    // Output assignments, all from flip-flops
    // ------------------------------------------------------------
    assign rx_clk = rx_clk_r;
    assign rxd = rxd_r;
    assign rx_dv_out = dv_out_r;
    assign rx_dv_oe = pins_oe_r;
    assign rx_er_out = er_out_r;
    assign rx_er_oe = pins_oe_r;
    assign col_out = col_out_r;
    assign col_oe = pins_oe_r;
    assign crs_out = crs_out_r;
    assign crs_oe = pins_oe_r;
    assign tx_clk_out = rx_clk_r;
    assign tx_clk_oe = txc_oe_r;
    assign tx_nib_valid = tx_valid_r;
    assign tx_nib = tx_nib_r;
    assign tx_nib_err = tx_err_r;
    assign coding_layer_loopback_strap = loop_r;
    assign port_detach_mode = detach_r;
    assign reduced_if_select_strap = rmii_r;
    assign reduced_if_back_to_back_strap = btb_r;
    assign port_running = state_r[2];

endmodule

/* testbench.sv */
// Self-checking bench for the media-independent port
`timescale 1ns/10ps
module testbench;
    import phymip_pkg::*;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic reset_n = 1'b0;
    logic speed_100 = 1'b1;
    logic rx_in_valid = 1'b0;
    logic [3:0] rx_in_data = 4'h0;
    logic rx_in_err = 1'b0;
    logic carrier_src = 1'b0;
    logic collision_src = 1'b0;
    logic [3:0] pull = 4'h0; // Strap levels: valid, error, collision, carrier
    logic rx_in_ready, rx_clk, rx_dv_out, rx_dv_oe, rx_er_out, rx_er_oe, col_out, col_oe;
    logic crs_out, crs_oe, tx_clk_oe, tx_nib_valid, tx_nib_err, port_running;
    logic coding_layer_loopback_strap, port_detach_mode;
    logic reduced_if_select_strap, reduced_if_back_to_back_strap;
    logic [3:0] rxd, tx_nib;
    wire tx_en, tx_er;
    wire [3:0] txd;
    // Pin levels: design drive when enabled, else the strap pull
    wire rx_dv_in = rx_dv_oe ? rx_dv_out : pull[3];
    wire rx_er_in = rx_er_oe ? rx_er_out : pull[2];
    wire col_in = col_oe ? col_out : pull[1];
    wire crs_in = crs_oe ? crs_out : pull[0];
    int error_cnt = 0;
    int tests_run = 0;
    // Rows: offered {err, nibble} beside the expected {err, nibble}
    logic [9:0] rows[6] = '{10'h000, 10'h1ef, 10'h0a5, 10'h35a, 10'h273, 10'h18c};
    always #5 clk = ~clk;
    // Reference clock from the far side, offset in phase
    initial begin
        #3.3;
        forever #80 link_clk = ~link_clk;
    end
    phymip_port i_phymip_port (.clk, .reset_n, .link_clk, .speed_100, .rx_in_valid,
        .rx_in_ready, .rx_in_data, .rx_in_err, .carrier_src, .collision_src, .rx_clk, .rxd,
        .rx_dv_in, .rx_dv_out, .rx_dv_oe, .rx_er_in, .rx_er_out, .rx_er_oe, .col_in, .col_out,
        .col_oe, .crs_in, .crs_out, .crs_oe, .tx_clk_out(), .tx_clk_oe, .tx_en, .tx_er, .txd,
        .tx_nib_valid, .tx_nib, .tx_nib_err, .coding_layer_loopback_strap, .port_detach_mode,
        .reduced_if_select_strap, .reduced_if_back_to_back_strap, .port_running);
    phymip_mac_model i_mac (.link_clk, .rx_clk, .rx_dv(rx_dv_in), .rx_er(rx_er_in), .rxd,
        .tx_en, .tx_er, .txd);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic fail_wait();
        error_cnt++;
        $display("[ERR] %0t wait ran out", $time);
        give_verdict();
    endtask
    // Hold reset with the given straps, then wait for the latch
    task automatic do_reset(input logic [3:0] straps, input logic spd);
        int t;
        @(negedge clk);
        reset_n = 1'b0;
        pull = straps;
        speed_100 = spd;
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        t = 0;
        while (port_running !== 1'b1 && t < 20) begin
            @(negedge clk);
            t++;
        end
        if (t == 20) fail_wait();
        @(negedge clk);
    endtask
    task automatic push(input logic [4:0] w);
        int t;
        rx_in_valid = 1'b1;
        rx_in_data = w[3:0];
        rx_in_err = w[4];
        t = 0;
        // Ready is looked at on the falling edge, where it has settled
        while (rx_in_ready !== 1'b1 && t < 200) begin
            @(negedge clk);
            t++;
        end
        if (t == 200) fail_wait();
        @(negedge clk);
        rx_in_valid = 1'b0;
    endtask
    task automatic wait_rx(input int n);
        int t;
        t = 0;
        while (i_mac.rx_q.size() < n && t < 3000) begin
            @(negedge clk);
            t++;
        end
        if (t == 3000) fail_wait();
    endtask
    task automatic wait_nib();
        int t;
        t = 0;
        while (tx_nib_valid !== 1'b1 && t < 100) begin
            @(negedge clk);
            t++;
        end
        if (t == 100) fail_wait();
    endtask
    initial begin
        int i;
        int acc;
        logic full;
        // Default straps at 100Mbps
        do_reset(4'h0, 1'b1);
        check({coding_layer_loopback_strap, port_detach_mode, reduced_if_select_strap,
            reduced_if_back_to_back_strap}, 4'h0);
        check({rx_dv_oe, rx_er_oe, col_oe, crs_oe, tx_clk_oe}, 5'h1f);
        for (i = 0; i < 6; i++) begin
            push(rows[i][9:5]);
            wait_rx(i + 1);
            check(i_mac.rx_q[i], rows[i][4:0]);
            i_mac.tx_q.push_back(rows[i][9:5]);
            wait_nib();
            check({tx_nib_err, tx_nib}, rows[i][4:0]);
        end
        // Medium status follows its sources
        collision_src = 1'b1;
        carrier_src = 1'b1;
        @(negedge clk);
        check({col_out, crs_out}, 2'h3);
        collision_src = 1'b0;
        carrier_src = 1'b0;
        @(negedge clk);
        check({col_out, crs_out}, 2'h0);
        // Back-to-back offers until the buffer refuses, then drain in order
        rx_in_valid = 1'b1;
        acc = 0;
        full = 1'b0;
        for (i = 0; i < 40 && !full; i++) begin
            rx_in_data = acc[3:0];
            if (rx_in_ready === 1'b1) begin
                acc++;
            end else begin
                full = 1'b1;
                rx_in_valid = 1'b0;
            end
            @(negedge clk);
        end
        rx_in_valid = 1'b0;
        check({full, 7'(acc >= 16)}, 8'h81);
        wait_rx(6 + acc);
        for (i = 0; i < acc; i++) begin
            check(i_mac.rx_q[6 + i], {4'h0, i[3:0]});
        end
        // Detach with reduced interface and back-to-back, then pins wiggle
        do_reset(4'h7, 1'b1);
        check({coding_layer_loopback_strap, port_detach_mode, reduced_if_select_strap,
            reduced_if_back_to_back_strap}, 4'h7);
        check({rx_dv_oe, rx_er_oe, col_oe, crs_oe, tx_clk_oe}, 5'h00);
        pull = 4'h8;
        repeat (3) @(negedge clk);
        check({coding_layer_loopback_strap, port_detach_mode, reduced_if_select_strap,
            reduced_if_back_to_back_strap}, 4'h7);
        // Loopback at 10Mbps; back-to-back needs the reduced interface
        do_reset(4'h9, 1'b0);
        check({coding_layer_loopback_strap, port_detach_mode, reduced_if_select_strap,
            reduced_if_back_to_back_strap}, 4'h8);
        check({rx_in_ready, rx_dv_oe, tx_clk_oe}, 3'h3);
        i_mac.rx_q.delete();
        i_mac.tx_q.push_back(5'h16);
        wait_rx(1);
        check(i_mac.rx_q[0], 5'h16);
        give_verdict();
    end
endmodule
